// file: ock_overlay_key.sv
/*
  Overlay colour keying: destination key, source chroma key, constant alpha and pipe
  assignment, with an AXI4-Lite register slave.
  Assumes pixel inputs synchronous to clk_in, one pixel per cycle when valid.
*/
// Behaviour
// - Hold 24-bit destination key, red green blue.
// - Matching display pixel in window shows overlay.
// - Destination keying puts overlay below primary.
// - Keying only on shared pipe, plane A first.
// - Mask one bits excluded from the compare.
// - Constant alpha scales every overlay channel.
// - Alpha ff opaque, zero transparent, proportional.
// - Source keying on zoomed data, before conversion.
// - Widen RGB channels by repeating top bits.
// - Above high key fails, overlay shown.
// - Below low key fails, inside range primary.
// - Channels are Y U V or G B R.
// - Per-channel enables gate the source result.
// - Destination failure wins; both fail gives primary.
// - Pipe change completes after both pipes blank.
`timescale 1ns/100ps
`include "ock_defines.svh"
module ock_overlay_key (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic vblank_a_in,
  input wire logic vblank_b_in,
  input wire logic plane_a_on_pipe_a_in,
  input wire logic plane_a_on_pipe_b_in,
  input wire logic plane_b_on_pipe_a_in,
  input wire logic plane_b_on_pipe_b_in,
  input wire logic pix_valid_in,
  input wire logic in_window_in,
  input wire logic [23:0] plane_a_pix_in,
  input wire logic [23:0] plane_b_pix_in,
  input wire logic [23:0] ovl_pix_in,
  input wire ock_pkg::ock_fmt_t ovl_fmt_in,
  output logic pix_valid_out,
  output logic show_overlay_out,
  output logic overlay_below_out,
  output logic [23:0] ovl_pix_out,
  output logic pipe_sel_out
);
  logic [31:0] dest_key_value_reg;
  logic [31:0] dest_key_mask_alpha_ctrl_reg;
  logic [31:0] source_key_high_reg;
  logic [31:0] source_key_low_reg;
  logic [31:0] source_key_enable_alpha_value_reg;
  logic [31:0] overlay_configuration_reg;
  logic [31:0] fr_dkv_reg;
  logic [31:0] fr_dkm_reg;
  logic [31:0] fr_skh_reg;
  logic [31:0] fr_skl_reg;
  logic [31:0] fr_ske_reg;
  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic frame_start;
  logic vblank_a_d_reg;
  logic vblank_b_d_reg;
  logic vblank_a_rise;
  logic vblank_b_rise;
  logic pipe_target_reg;
  ock_pkg::ock_pipe_state_t pipe_state_reg;
  logic [23:0] key_pix;
  logic key_plane_present;
  logic dest_fail;
  logic src_fail;
  logic [23:0] ovl_wide;
  logic [23:0] ovl_scaled;
  logic s1_valid_reg;
  logic s1_show_reg;
  logic [23:0] s1_pix_reg;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb, input logic [31:0] keep);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res & keep;
  endfunction : merge_bytes

  function automatic logic [7:0] scale8(input logic [7:0] chan, input logic [7:0] alpha);
    logic [15:0] prod;
    prod = chan * alpha + 16'h0080;
    prod = prod + {8'h00, prod[15:8]};
    return prod[15:8];
  endfunction : scale8

  // AXI4-Lite write path: address and data are latched independently.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid_in && s_axi_awready_out) begin
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr_in;
    end else if (aw_hold_reg && w_hold_reg && !s_axi_bvalid_out) begin
      aw_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid_in && s_axi_wready_out) begin
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata_in;
      w_strb_reg <= s_axi_wstrb_in;
    end else if (aw_hold_reg && w_hold_reg && !s_axi_bvalid_out) begin
      w_hold_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
    end else begin
      s_axi_awready_out <= !aw_hold_reg && !(s_axi_awvalid_in && s_axi_awready_out) && !s_axi_bvalid_out;
      s_axi_wready_out <= !w_hold_reg && !(s_axi_wvalid_in && s_axi_wready_out) && !s_axi_bvalid_out;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'h0;
    end else if (aw_hold_reg && w_hold_reg && !s_axi_bvalid_out) begin
      s_axi_bvalid_out <= 1'b1;
      s_axi_bresp_out <= (aw_addr_reg[7:2] >= `OCK_OFS_DEST_KEY_VALUE >> 2 &&
                          aw_addr_reg[7:2] <= `OCK_OFS_OVL_CONFIG >> 2) ? 2'h0 : 2'h2;
    end else if (s_axi_bready_in) begin
      s_axi_bvalid_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      dest_key_value_reg <= `OCK_RST_DEST_KEY_VALUE;
      dest_key_mask_alpha_ctrl_reg <= `OCK_RST_DEST_KEY_MASK;
      source_key_high_reg <= `OCK_RST_SRC_KEY_HIGH;
      source_key_low_reg <= `OCK_RST_SRC_KEY_LOW;
      source_key_enable_alpha_value_reg <= `OCK_RST_SRC_KEY_EN;
      overlay_configuration_reg <= `OCK_RST_OVL_CONFIG;
    end else if (aw_hold_reg && w_hold_reg && !s_axi_bvalid_out) begin
      unique case ({aw_addr_reg[7:2], 2'b00})
        `OCK_OFS_DEST_KEY_VALUE: begin
          dest_key_value_reg <= merge_bytes(dest_key_value_reg, w_data_reg, w_strb_reg,
                                            `OCK_MASK_DEST_KEY_VALUE);
        end
        `OCK_OFS_DEST_KEY_MASK: begin
          dest_key_mask_alpha_ctrl_reg <= merge_bytes(dest_key_mask_alpha_ctrl_reg, w_data_reg, w_strb_reg,
                                                      `OCK_MASK_DEST_KEY_MASK);
        end
        `OCK_OFS_SRC_KEY_HIGH: begin
          source_key_high_reg <= merge_bytes(source_key_high_reg, w_data_reg, w_strb_reg, `OCK_MASK_SRC_KEY);
        end
        `OCK_OFS_SRC_KEY_LOW: begin
          source_key_low_reg <= merge_bytes(source_key_low_reg, w_data_reg, w_strb_reg, `OCK_MASK_SRC_KEY);
        end
        `OCK_OFS_SRC_KEY_EN: begin
          source_key_enable_alpha_value_reg <= merge_bytes(source_key_enable_alpha_value_reg, w_data_reg,
                                                           w_strb_reg, `OCK_MASK_SRC_KEY_EN);
        end
        `OCK_OFS_OVL_CONFIG: begin
          overlay_configuration_reg <= merge_bytes(overlay_configuration_reg, w_data_reg, w_strb_reg,
                                                   `OCK_MASK_OVL_CONFIG);
        end
        default: begin
        end
      endcase
    end
  end

  // AXI4-Lite read path; unmapped addresses answer SLVERR with zero data.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= 2'h0;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out <= 2'h0;
      unique case ({s_axi_araddr_in[7:2], 2'b00})
        `OCK_OFS_DEST_KEY_VALUE: s_axi_rdata_out <= dest_key_value_reg;
        `OCK_OFS_DEST_KEY_MASK: s_axi_rdata_out <= dest_key_mask_alpha_ctrl_reg;
        `OCK_OFS_SRC_KEY_HIGH: s_axi_rdata_out <= source_key_high_reg;
        `OCK_OFS_SRC_KEY_LOW: s_axi_rdata_out <= source_key_low_reg;
        `OCK_OFS_SRC_KEY_EN: s_axi_rdata_out <= source_key_enable_alpha_value_reg;
        `OCK_OFS_OVL_CONFIG: s_axi_rdata_out <= overlay_configuration_reg;
        `OCK_OFS_OVL_STATUS: s_axi_rdata_out <= {30'h00000000, pipe_state_reg != ock_pkg::ock_pipe_idle,
                                                 pipe_sel_out};
        default: begin
          s_axi_rdata_out <= 32'h00000000;
          s_axi_rresp_out <= 2'h2;
        end
      endcase
    end else if (s_axi_rvalid_out) begin
      if (s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end else begin
      s_axi_arready_out <= 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      vblank_a_d_reg <= 1'b0;
      vblank_b_d_reg <= 1'b0;
    end else begin
      vblank_a_d_reg <= vblank_a_in;
      vblank_b_d_reg <= vblank_b_in;
    end
  end

  assign vblank_a_rise = vblank_a_in && !vblank_a_d_reg;
  assign vblank_b_rise = vblank_b_in && !vblank_b_d_reg;

  // pipe switch handshake.
  // The old pipe blanks first, then the new one, so neither pipe sees a torn frame.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      pipe_state_reg <= ock_pkg::ock_pipe_idle;
      pipe_target_reg <= 1'b0;
      pipe_sel_out <= 1'b0;
    end else begin
      unique case (pipe_state_reg)
        ock_pkg::ock_pipe_idle: begin
          if (overlay_configuration_reg[`OCK_BIT_PIPE_SEL] != pipe_sel_out) begin
            pipe_target_reg <= overlay_configuration_reg[`OCK_BIT_PIPE_SEL];
            pipe_state_reg <= ock_pkg::ock_pipe_wait_first;
          end
        end
        ock_pkg::ock_pipe_wait_first: begin
          if (pipe_sel_out ? vblank_b_rise : vblank_a_rise) begin
            pipe_state_reg <= ock_pkg::ock_pipe_wait_second;
          end
        end
        ock_pkg::ock_pipe_wait_second: begin
          if (pipe_target_reg ? vblank_b_rise : vblank_a_rise) begin
            pipe_sel_out <= pipe_target_reg;
            pipe_state_reg <= ock_pkg::ock_pipe_idle;
          end
        end
        default: begin
          pipe_state_reg <= ock_pkg::ock_pipe_idle;
        end
      endcase
    end
  end

  assign frame_start = pipe_sel_out ? vblank_b_rise : vblank_a_rise;

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      fr_dkv_reg <= `OCK_RST_DEST_KEY_VALUE;
      fr_dkm_reg <= `OCK_RST_DEST_KEY_MASK;
      fr_skh_reg <= `OCK_RST_SRC_KEY_HIGH;
      fr_skl_reg <= `OCK_RST_SRC_KEY_LOW;
      fr_ske_reg <= `OCK_RST_SRC_KEY_EN;
    end else if (frame_start) begin
      fr_dkv_reg <= dest_key_value_reg;
      fr_dkm_reg <= dest_key_mask_alpha_ctrl_reg;
      fr_skh_reg <= source_key_high_reg;
      fr_skl_reg <= source_key_low_reg;
      fr_ske_reg <= source_key_enable_alpha_value_reg;
    end
  end

  // plane A preferred on shared pipe.
  always_comb begin
    key_plane_present = 1'b0;
    key_pix = plane_a_pix_in;
    if (pipe_sel_out ? plane_a_on_pipe_b_in : plane_a_on_pipe_a_in) begin
      key_plane_present = 1'b1;
    end else if (pipe_sel_out ? plane_b_on_pipe_b_in : plane_b_on_pipe_a_in) begin
      key_plane_present = 1'b1;
      key_pix = plane_b_pix_in;
    end
  end

  assign dest_fail = fr_dkm_reg[`OCK_BIT_DEST_KEY_EN] && (!key_plane_present || !in_window_in ||
                     ((key_pix ^ fr_dkv_reg[23:0]) & ~fr_dkm_reg[23:0]) != 24'h000000);

  always_comb begin
    unique case (ovl_fmt_in)
      ock_pkg::ock_fmt_rgb_five_five_five: begin
        ovl_wide = {ovl_pix_in[20:16], ovl_pix_in[20:18], ovl_pix_in[12:8], ovl_pix_in[12:10],
                    ovl_pix_in[4:0], ovl_pix_in[4:2]};
      end
      ock_pkg::ock_fmt_rgb_five_six_five: begin
        ovl_wide = {ovl_pix_in[21:16], ovl_pix_in[21:20], ovl_pix_in[12:8], ovl_pix_in[12:10],
                    ovl_pix_in[4:0], ovl_pix_in[4:2]};
      end
      default: begin
        ovl_wide = ovl_pix_in;
      end
    endcase
  end

  always_comb begin
    src_fail = 1'b0;
    for (int c = 0; c < 3; c++) begin
      if (fr_ske_reg[`OCK_BIT_CR_RED_EN + c] &&
          (ovl_wide[c*8 +: 8] > fr_skh_reg[c*8 +: 8] || ovl_wide[c*8 +: 8] < fr_skl_reg[c*8 +: 8])) begin
        src_fail = 1'b1;
      end
    end
  end

  generate
    for (genvar g = 0; g < 3; g++) begin : g_alpha
      assign ovl_scaled[g*8 +: 8] = fr_dkm_reg[`OCK_BIT_ALPHA_EN] ?
                                    scale8(ovl_wide[g*8 +: 8], fr_ske_reg[7:0]) : ovl_wide[g*8 +: 8];
    end
  endgenerate

  // two-stage pixel pipeline.
  // A disabled channel never fails; with no channel enabled the source key is bypassed and the overlay is shown unless the destination key fails.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      s1_valid_reg <= 1'b0;
      s1_show_reg <= 1'b0;
      s1_pix_reg <= 24'h000000;
      pix_valid_out <= 1'b0;
      show_overlay_out <= 1'b0;
      ovl_pix_out <= 24'h000000;
    end else begin
      s1_valid_reg <= pix_valid_in;
      if (dest_fail) begin
        s1_show_reg <= 1'b0;
      end else if (fr_ske_reg[26:24] != 3'b000) begin
        s1_show_reg <= src_fail;
      end else begin
        s1_show_reg <= 1'b1;
      end
      s1_pix_reg <= ovl_scaled;
      pix_valid_out <= s1_valid_reg;
      show_overlay_out <= s1_show_reg;
      ovl_pix_out <= s1_pix_reg;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      overlay_below_out <= 1'b0;
    end else begin
      overlay_below_out <= fr_dkm_reg[`OCK_BIT_DEST_KEY_EN];
    end
  end
endmodule : ock_overlay_key

// file: ock_defines.svh
/*
  Register offsets, field positions and reset values of the overlay keying block.
  Assumes inclusion by bare name from the design file.
*/
`ifndef OCK_DEFINES_SVH
`define OCK_DEFINES_SVH
`define OCK_OFS_DEST_KEY_VALUE 8'h50
`define OCK_OFS_DEST_KEY_MASK 8'h54
`define OCK_OFS_SRC_KEY_HIGH 8'h58
`define OCK_OFS_SRC_KEY_LOW 8'h5c
`define OCK_OFS_SRC_KEY_EN 8'h60
`define OCK_OFS_OVL_CONFIG 8'h64
`define OCK_OFS_OVL_STATUS 8'h68
`define OCK_BIT_DEST_KEY_EN 31
`define OCK_BIT_ALPHA_EN 30
`define OCK_BIT_LUMA_GREEN_EN 26
`define OCK_BIT_CB_BLUE_EN 25
`define OCK_BIT_CR_RED_EN 24
`define OCK_BIT_PIPE_SEL 18
`define OCK_RST_DEST_KEY_VALUE 32'h00000000
`define OCK_RST_DEST_KEY_MASK 32'h00000000
`define OCK_RST_SRC_KEY_HIGH 32'h00000000
`define OCK_RST_SRC_KEY_LOW 32'h00000000
`define OCK_RST_SRC_KEY_EN 32'h00000000
`define OCK_RST_OVL_CONFIG 32'h00000000
`define OCK_MASK_DEST_KEY_VALUE 32'h00ffffff
`define OCK_MASK_DEST_KEY_MASK 32'hc0ffffff
`define OCK_MASK_SRC_KEY 32'h00ffffff
`define OCK_MASK_SRC_KEY_EN 32'h070000ff
`define OCK_MASK_OVL_CONFIG 32'h07fc0000
`define OCK_ALPHA_FULL 8'hff
`endif

// file: ock_pkg.sv
/*
  Types shared by the overlay keying block.
  Assumes nothing of its surroundings.
*/
package ock_pkg;
  typedef enum logic [1:0] {
    ock_fmt_rgb888,
    ock_fmt_rgb_five_five_five,
    ock_fmt_rgb_five_six_five,
    ock_fmt_yuv
  } ock_fmt_t;
  typedef enum logic [1:0] {
    ock_pipe_idle,
    ock_pipe_wait_first,
    ock_pipe_wait_second
  } ock_pipe_state_t;
endpackage : ock_pkg

// file: ock_overlay_key_assertions.sv
/*
  Checker of the overlay keying block: bus handshakes, pixel latency and frame updates.
  Assumes it is bound to the block's top module and sees only its ports.
*/
`timescale 1ns/100ps
module ock_overlay_key_checker (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [1:0] s_axi_bresp_out,
  input wire logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic s_axi_arvalid_in,
  input wire logic s_axi_arready_out,
  input wire logic [31:0] s_axi_rdata_out,
  input wire logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic vblank_a_in,
  input wire logic vblank_b_in,
  input wire logic pix_valid_in,
  input wire logic pix_valid_out,
  input wire logic overlay_below_out,
  input wire logic pipe_sel_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  pix_latency_a: assert property (pix_valid_in |-> ##2 pix_valid_out)
    else $error("pixel valid not delayed by two cycles");
  pix_gap_a: assert property (!pix_valid_in |-> ##2 !pix_valid_out)
    else $error("pixel valid without an input pixel");
  bresp_hold_a: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out))
    else $error("read data dropped before taken");
  read_answer_a: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
    else $error("read answer late");
  write_answer_a: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
    |-> ##[1:2] s_axi_bvalid_out)
    else $error("write answer late");
  write_refuse_a: assert property (s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("write accepted while response pending");
  read_refuse_a: assert property (s_axi_rvalid_out |-> !s_axi_arready_out)
    else $error("read accepted while data pending");
  pipe_switch_a: assert property ($changed(pipe_sel_out) |-> (pipe_sel_out ? ($past(vblank_b_in) || vblank_b_in)
    : ($past(vblank_a_in) || vblank_a_in)))
    else $error("pipe changed outside the new pipe blank");
  below_frame_a: assert property ($changed(overlay_below_out) |-> $past(vblank_a_in) || $past(vblank_b_in)
    || vblank_a_in || vblank_b_in)
    else $error("plane order changed outside a blank");
endmodule : ock_overlay_key_checker
bind ock_overlay_key ock_overlay_key_checker u_checker (.*);

// file: ock_display_model.sv
/*
  Display pipe model: raises a pipe's vertical blank for three cycles on request.
  Assumes one-cycle requests on the block's clock.
*/
`timescale 1ns/100ps
module ock_display_model (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic vb_req_a_in,
  input wire logic vb_req_b_in,
  output logic vblank_a_out,
  output logic vblank_b_out
);
  logic [1:0] cnt_a_reg;
  logic [1:0] cnt_b_reg;
  // Three cycles, so a registered edge detector in the block still sees the blank.
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) cnt_a_reg <= 2'h0;
    else if (vb_req_a_in) cnt_a_reg <= 2'h3;
    else if (cnt_a_reg != 2'h0) cnt_a_reg <= cnt_a_reg - 2'h1;
  end
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) cnt_b_reg <= 2'h0;
    else if (vb_req_b_in) cnt_b_reg <= 2'h3;
    else if (cnt_b_reg != 2'h0) cnt_b_reg <= cnt_b_reg - 2'h1;
  end
  assign vblank_a_out = (cnt_a_reg != 2'h0);
  assign vblank_b_out = (cnt_b_reg != 2'h0);
endmodule : ock_display_model

// file: ock_overlay_key_bench.sv
/*
  Self-checking bench of the overlay keying block.
  Assumes the package, the block, its checker and the display model are compiled first.
*/
`timescale 1ns/100ps
module ock_overlay_key_bench;
  logic clk_in, rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic vblank_a_in, vblank_b_in, pix_valid_in, in_window_in, pix_valid_out, show_overlay_out;
  logic plane_a_on_pipe_a_in, plane_a_on_pipe_b_in, plane_b_on_pipe_a_in, plane_b_on_pipe_b_in;
  logic overlay_below_out, pipe_sel_out, vb_req_a, vb_req_b;
  logic [23:0] plane_a_pix_in, plane_b_pix_in, ovl_pix_in, ovl_pix_out;
  ock_pkg::ock_fmt_t ovl_fmt_in;
  int fail_count = 0;
  int comparisons = 0;
  ock_overlay_key DUT (.*);
  ock_display_model u_disp (.clk_in(clk_in), .rst_b_in(rst_b_in), .vb_req_a_in(vb_req_a), .vb_req_b_in(vb_req_b),
    .vblank_a_out(vblank_a_in), .vblank_b_out(vblank_b_in));
  task automatic summarize();
    if (fail_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : summarize
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (n > 50) fail_count++;
      if (n > 50) summarize();
    end while (!s_axi_bvalid_out);
    // Bready stays up, so a following call never lowers and raises it in one time step.
    cmp(32'(s_axi_bresp_out), 32'(er));
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge clk_in);
      n++;
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (n > 50) fail_count++;
      if (n > 50) summarize();
    end while (!s_axi_rvalid_out);
    cmp(s_axi_rdata_out, ed);
    cmp(32'(s_axi_rresp_out), 32'(er));
  endtask : rd
  // Keying settings only land at a blank of the overlay's pipe.
  task automatic vb(input logic pipe_b);
    if (pipe_b) vb_req_b <= 1'b1;
    else vb_req_a <= 1'b1;
    @(posedge clk_in);
    vb_req_a <= 1'b0;
    vb_req_b <= 1'b0;
    repeat (5) @(posedge clk_in);
  endtask : vb
  task automatic px(input logic [23:0] a, input logic [23:0] b, input logic [23:0] o, input logic es,
    input logic [23:0] eo);
    plane_a_pix_in <= a;
    plane_b_pix_in <= b;
    ovl_pix_in <= o;
    pix_valid_in <= 1'b1;
    @(posedge clk_in);
    pix_valid_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    cmp(32'(pix_valid_out), 32'h1);
    cmp(32'(show_overlay_out), 32'(es));
    cmp(32'(ovl_pix_out), 32'(eo));
  endtask : px
  function automatic logic [7:0] sc(input logic [7:0] c, input logic [7:0] a);
    logic [15:0] t;
    t = c * a + 16'h0080;
    return 8'((t + (t >> 8)) >> 8);
  endfunction : sc
  task automatic t_regs();
    for (int i = 0; i < 6; i++) rd(8'(8'h50 + 4 * i), 32'h0, 2'h0);
    rd(8'h70, 32'h0, 2'h2);
    wr(8'h70, 32'h1, 2'h2);
    wr(8'h50, 32'hffffffff, 2'h0);
    rd(8'h50, 32'h00ffffff, 2'h0);
    wr(8'h54, 32'hffffffff, 2'h0);
    rd(8'h54, 32'hc0ffffff, 2'h0);
    wr(8'h60, 32'hffffffff, 2'h0);
    rd(8'h60, 32'h070000ff, 2'h0);
    wr(8'h60, 32'h0, 2'h0);
  endtask : t_regs
  task automatic t_dest();
    wr(8'h50, 32'h009050f8, 2'h0);
    wr(8'h54, 32'h80070707, 2'h0);
    vb(1'b0);
    cmp(32'(overlay_below_out), 32'h1);
    px(24'h9757ff, 24'h0, 24'h123456, 1'b1, 24'h123456);
    px(24'h9850f8, 24'h0, 24'h123456, 1'b0, 24'h123456);
    in_window_in <= 1'b0;
    px(24'h9050f8, 24'h0, 24'h123456, 1'b0, 24'h123456);
    in_window_in <= 1'b1;
    plane_a_on_pipe_a_in <= 1'b0;
    plane_a_on_pipe_b_in <= 1'b1;
    plane_b_on_pipe_a_in <= 1'b1;
    px(24'h0, 24'h9050f8, 24'h123456, 1'b1, 24'h123456);
    plane_a_on_pipe_a_in <= 1'b1;
    px(24'h0, 24'h9050f8, 24'h123456, 1'b0, 24'h123456);
    plane_a_on_pipe_a_in <= 1'b0;
    plane_b_on_pipe_a_in <= 1'b0;
    px(24'h9050f8, 24'h9050f8, 24'h123456, 1'b0, 24'h123456);
    plane_a_on_pipe_a_in <= 1'b1;
    wr(8'h54, 32'h80ffffff, 2'h0);
    vb(1'b0);
    px(24'h0f0f0f, 24'h0, 24'h123456, 1'b1, 24'h123456);
  endtask : t_dest
  task automatic t_src();
    logic [23:0] ov [6] = '{24'h607080, 24'h817080, 24'h3f7080, 24'h8090a0, 24'h405060, 24'h6070a1};
    logic ex [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    wr(8'h54, 32'h0, 2'h0);
    wr(8'h58, 32'h008090a0, 2'h0);
    wr(8'h5c, 32'h00405060, 2'h0);
    wr(8'h60, 32'h07000000, 2'h0);
    vb(1'b0);
    cmp(32'(overlay_below_out), 32'h0);
    for (int i = 0; i < 6; i++) px(24'h0, 24'h0, ov[i], ex[i], ov[i]);
    wr(8'h60, 32'h03000000, 2'h0);
    vb(1'b0);
    px(24'h0, 24'h0, 24'hff7080, 1'b0, 24'hff7080);
  endtask : t_src
  task automatic t_rgb();
    wr(8'h60, 32'h0, 2'h0);
    vb(1'b0);
    ovl_fmt_in <= ock_pkg::ock_fmt_rgb_five_six_five;
    px(24'h0, 24'h0, 24'h2d130c, 1'b1, 24'hb69c63);
    ovl_fmt_in <= ock_pkg::ock_fmt_rgb_five_five_five;
    px(24'h0, 24'h0, 24'h15130c, 1'b1, 24'had9c63);
    ovl_fmt_in <= ock_pkg::ock_fmt_yuv;
  endtask : t_rgb
  task automatic t_alpha();
    logic [7:0] al [3] = '{8'h80, 8'hff, 8'h00};
    logic [23:0] o;
    o = 24'hff8001;
    wr(8'h54, 32'h40000000, 2'h0);
    for (int i = 0; i < 3; i++) begin
      wr(8'h60, 32'(al[i]), 2'h0);
      vb(1'b0);
      px(24'h0, 24'h0, o, 1'b1, {sc(o[23:16], al[i]), sc(o[15:8], al[i]), sc(o[7:0], al[i])});
    end
  endtask : t_alpha
  task automatic t_both();
    wr(8'h50, 32'h0, 2'h0);
    wr(8'h54, 32'h80000000, 2'h0);
    wr(8'h58, 32'h0, 2'h0);
    wr(8'h5c, 32'h0, 2'h0);
    wr(8'h60, 32'h07000000, 2'h0);
    vb(1'b0);
    px(24'h111111, 24'h0, 24'h808080, 1'b0, 24'h808080);
    px(24'h0, 24'h0, 24'h808080, 1'b1, 24'h808080);
  endtask : t_both
  task automatic t_pipe();
    wr(8'h64, 32'h00040000, 2'h0);
    rd(8'h64, 32'h00040000, 2'h0);
    rd(8'h68, 32'h00000002, 2'h0);
    vb(1'b1);
    cmp(32'(pipe_sel_out), 32'h0);
    vb(1'b0);
    cmp(32'(pipe_sel_out), 32'h0);
    vb(1'b1);
    cmp(32'(pipe_sel_out), 32'h1);
    rd(8'h68, 32'h00000001, 2'h0);
  endtask : t_pipe
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    {rst_b_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    {s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in, vb_req_a, vb_req_b, pix_valid_in} = '0;
    {plane_a_on_pipe_b_in, plane_b_on_pipe_a_in, plane_b_on_pipe_b_in, plane_a_pix_in, plane_b_pix_in} = '0;
    s_axi_wstrb_in = 4'hf;
    in_window_in = 1'b1;
    plane_a_on_pipe_a_in = 1'b1;
    ovl_pix_in = 24'h0;
    ovl_fmt_in = ock_pkg::ock_fmt_yuv;
    repeat (6) @(posedge clk_in);
    rst_b_in <= 1'b1;
    @(posedge clk_in);
    t_regs();
    t_dest();
    t_src();
    t_rgb();
    t_alpha();
    t_both();
    t_pipe();
    summarize();
  end
endmodule : ock_overlay_key_bench
